//--- logic/pcfg_consts.svh
// constants for the configuration header tail and power capability entry
// ==========================================================================
`ifndef PCFG_CONSTS_SVH
`define PCFG_CONSTS_SVH

// ==========================================================================
// register offsets, byte addresses on the config port
`define PCFG_OFF_ROM_CTRL 8'h30
`define PCFG_OFF_CAP_PTR 8'h34
`define PCFG_OFF_IRQ_LINE 8'h3C
`define PCFG_OFF_IRQ_PIN 8'h3D
`define PCFG_OFF_MIN_GNT 8'h3E
`define PCFG_OFF_MAX_LAT 8'h3F
`define PCFG_OFF_CAP_ID 8'hDC
`define PCFG_OFF_NEXT_PTR 8'hDD
`define PCFG_OFF_PM_CAP 8'hDE

// ==========================================================================
// fixed read values and reset values
`define PCFG_CAP_PTR_VAL 8'hDC
`define PCFG_IRQ_PIN_VAL 8'h01
`define PCFG_CAP_ID_VAL 8'h01
`define PCFG_NEXT_PTR_VAL 8'h00
`define PCFG_PM_VERSION 3'h1
`define PCFG_IRQ_LINE_RST 8'h00
`define PCFG_ROM_BASE_RST 16'h0000
`define PCFG_MIN_GNT_RST 8'h06
`define PCFG_MAX_LAT_RST 8'h20
`define PCFG_PARAMS_RST 16'h3800

// ==========================================================================
// field positions
`define PCFG_ROM_BASE_HI 31
`define PCFG_ROM_BASE_LO 16
`define PCFG_ROM_DEC_BIT 0
`define PCFG_EE_D1_BIT 12
`define PCFG_EE_D2_BIT 13
`define PCFG_EE_WAKE_HI 15
`define PCFG_EE_WAKE_LO 11

// ==========================================================================
// timing: grant and latency unit against the 100 MHz clock
`define PCFG_CLK_PERIOD_NS 10
`define PCFG_GNT_UNIT_NS 250
`define PCFG_GNT_UNIT_CYC (`PCFG_GNT_UNIT_NS / `PCFG_CLK_PERIOD_NS)

`endif

//--- logic/pcfg_pkg.sv
// types for the configuration header tail block
package pcfg_pkg;

  // ========================================================================
  // state of the eeprom parameter latch
  typedef struct packed {
    logic [15:0] params;  // bus parameter word
    logic [7:0] min_gnt;  // burst period, 250 ns units
    logic [7:0] max_lat;  // access interval, 250 ns units
    logic loaded;         // an eeprom word has arrived
  } pcfg_latch_type;

  // ========================================================================
  // state of the register bank top
  typedef struct packed {
    logic [15:0] rom_base;  // rom window base
    logic rom_dec;          // rom decode enable
    logic [7:0] irq_line;   // interrupt line number
    logic [31:0] rdata;     // read data, one cycle after strobe
    logic claim;            // rom window claim
    logic [12:0] gnt_cyc;   // min grant in clock cycles
    logic [12:0] lat_cyc;   // max latency in clock cycles
  } pcfg_state_type;

endpackage : pcfg_pkg

//--- logic/pcfg_param_latch.sv
// latch for the eeprom-loaded bus parameter, grant and latency values
`include "pcfg_consts.svh"

module pcfg_param_latch (
  input wire logic clk,             // 100 MHz clock
  input wire logic rst_b,           // async reset, active low
  input wire logic ee_word_valid,   // one-cycle strobe from eeprom reader
  input wire logic ee_word_sel,     // 0: params word, 1: {max_lat, min_gnt}
  input wire logic [15:0] ee_word,  // word read from eeprom
  output logic [15:0] params_word,  // bus parameter word
  output logic [7:0] min_gnt,       // burst period value
  output logic [7:0] max_lat,       // access interval value
  output logic loaded               // set once any word is taken
);

  // ========================================================================
  // state
  pcfg_pkg::pcfg_latch_type st_r;    // registered state
  pcfg_pkg::pcfg_latch_type st_nxt;  // next state

  // ========================================================================
  // next state: a strobe overwrites the selected word
  always_comb begin
    st_nxt = st_r;
    if (ee_word_valid) begin
      st_nxt.loaded = 1'b1;
      if (ee_word_sel) begin  // grant and latency word
        st_nxt.min_gnt = ee_word[7:0];
        st_nxt.max_lat = ee_word[15:8];
      end else begin          // parameter word
        st_nxt.params = ee_word;
      end
    end
  end

  // ========================================================================
  // registers; shipped values stand until the eeprom has been read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r.params <= `PCFG_PARAMS_RST;
      st_r.min_gnt <= `PCFG_MIN_GNT_RST;
      st_r.max_lat <= `PCFG_MAX_LAT_RST;
      st_r.loaded <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs come from the flops
  assign params_word = st_r.params;
  assign min_gnt = st_r.min_gnt;
  assign max_lat = st_r.max_lat;
  assign loaded = st_r.loaded;

endmodule // pcfg_param_latch

//--- logic/pcfg_tail.sv
// configuration header tail and power capability register bank
`include "pcfg_consts.svh"

module pcfg_tail (
  input wire logic clk,                    // 100 MHz clock
  input wire logic rst_b,                  // async reset, active low
  input wire logic [7:0] cfg_addr,         // config byte offset
  input wire logic [31:0] cfg_wdata,       // config write data
  input wire logic cfg_wr,                 // write strobe, one cycle
  input wire logic cfg_rd,                 // read strobe, one cycle
  output logic [31:0] cfg_rdata,           // read data, cycle after strobe
  input wire logic mem_space_on,           // memory space enable from command
  input wire logic rom_acc_valid,          // memory access presented
  input wire logic [31:0] rom_acc_addr,    // memory access address
  output logic rom_claim,                  // access falls in rom window
  output logic rom_decode_on,              // rom decode enable bit
  output logic [15:0] rom_window_base,     // rom window base field
  output logic [7:0] irq_line_number,      // interrupt line for drivers
  input wire logic ee_word_valid,          // eeprom word strobe
  input wire logic ee_word_sel,            // eeprom word select
  input wire logic [15:0] ee_word,         // eeprom word
  output logic [12:0] grant_cycles,        // min grant in clock cycles
  output logic [12:0] latency_cycles       // max latency in clock cycles
);

  // ========================================================================
  // address match, used by the write decode; the window compare checks address bits itself
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ========================================================================
  // state
  pcfg_pkg::pcfg_state_type st_r;    // registered state
  pcfg_pkg::pcfg_state_type st_nxt;  // next state

  // eeprom-derived values from the latch
  logic [15:0] eeprom_bus_params_word;  // bus parameter word
  logic [7:0] min_burst_grant;          // burst period value
  logic [7:0] max_bus_latency;          // access interval value
  logic params_loaded;                  // eeprom word seen

  // combinational read view
  logic [15:0] power_capabilities;  // assembled capability word
  logic [31:0] rom_window_control;  // assembled rom control word
  logic [31:0] read_word;           // selected read value

  // ========================================================================
  // eeprom parameter latch
  pcfg_param_latch u_latch (
    .clk(clk),
    .rst_b(rst_b),
    .ee_word_valid(ee_word_valid),
    .ee_word_sel(ee_word_sel),
    .ee_word(ee_word),
    .params_word(eeprom_bus_params_word),
    .min_gnt(min_burst_grant),
    .max_lat(max_bus_latency),
    .loaded(params_loaded)
  );

  // ========================================================================
  // assembled words
  // power capability: wake mask and d1/d2 straight from eeprom,
  // aux power and pme clock hard zero, reserved bits zero
  always_comb begin
    power_capabilities = {
      eeprom_bus_params_word[`PCFG_EE_WAKE_HI:`PCFG_EE_WAKE_LO],
      eeprom_bus_params_word[`PCFG_EE_D2_BIT],
      eeprom_bus_params_word[`PCFG_EE_D1_BIT],
      4'h0,                  // reserved
      1'b0,                  // no aux power
      1'b0,                  // no clock needed for wake
      `PCFG_PM_VERSION
    };
    // rom control: bits 15:1 have no storage and read zero
    rom_window_control = {st_r.rom_base, 15'h0000, st_r.rom_dec};
  end

  // ========================================================================
  // read mux; narrow registers sit in the low bits, unmapped reads zero
  always_comb begin
    read_word = 32'h0000_0000;
    case (cfg_addr)
      `PCFG_OFF_ROM_CTRL: begin
        read_word = rom_window_control;
      end
      `PCFG_OFF_CAP_PTR: begin
        read_word = {24'h00_0000, `PCFG_CAP_PTR_VAL};
      end
      `PCFG_OFF_IRQ_LINE: begin
        read_word = {24'h00_0000, st_r.irq_line};
      end
      `PCFG_OFF_IRQ_PIN: begin
        read_word = {24'h00_0000, `PCFG_IRQ_PIN_VAL};
      end
      `PCFG_OFF_MIN_GNT: begin
        read_word = {24'h00_0000, min_burst_grant};
      end
      `PCFG_OFF_MAX_LAT: begin
        read_word = {24'h00_0000, max_bus_latency};
      end
      `PCFG_OFF_CAP_ID: begin
        read_word = {24'h00_0000, `PCFG_CAP_ID_VAL};
      end
      `PCFG_OFF_NEXT_PTR: begin
        read_word = {24'h00_0000, `PCFG_NEXT_PTR_VAL};
      end
      `PCFG_OFF_PM_CAP: begin
        read_word = {16'h0000, power_capabilities};
      end
      default: begin
        read_word = 32'h0000_0000;  // unmapped
      end
    endcase
  end

  // ========================================================================
  // next state: writes, read data, window claim, timing hints
  always_comb begin
    st_nxt = st_r;
    // rom control: only base and decode enable take write data
    if (cfg_wr && hit(cfg_addr, `PCFG_OFF_ROM_CTRL)) begin
      st_nxt.rom_base = cfg_wdata[`PCFG_ROM_BASE_HI:`PCFG_ROM_BASE_LO];
      st_nxt.rom_dec = cfg_wdata[`PCFG_ROM_DEC_BIT];
    end
    // interrupt line is kept for the driver even though nothing here uses it
    if (cfg_wr && hit(cfg_addr, `PCFG_OFF_IRQ_LINE)) begin
      st_nxt.irq_line = cfg_wdata[7:0];
    end
    // read data stand only in the cycle after the strobe
    if (cfg_rd) begin
      st_nxt.rdata = read_word;
    end else begin
      st_nxt.rdata = 32'h0000_0000;
    end
    // window claim: compare upper 16 address bits, 64 KB granules;
    // the settings in force before a same-cycle write are used
    st_nxt.claim = rom_acc_valid && st_r.rom_dec && mem_space_on
                   && (rom_acc_addr[31:16] == st_r.rom_base);
    // timing hints for the bus master, recomputed every cycle
    st_nxt.gnt_cyc = 13'(min_burst_grant) * 13'(`PCFG_GNT_UNIT_CYC);
    st_nxt.lat_cyc = 13'(max_bus_latency) * 13'(`PCFG_GNT_UNIT_CYC);
  end

  // ========================================================================
  // registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r.rom_base <= `PCFG_ROM_BASE_RST;
      st_r.rom_dec <= 1'b0;  // window off after reset
      st_r.irq_line <= `PCFG_IRQ_LINE_RST;
      st_r.rdata <= 32'h0000_0000;
      st_r.claim <= 1'b0;
      st_r.gnt_cyc <= 13'h0000;
      st_r.lat_cyc <= 13'h0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ========================================================================
  // outputs, all straight from flops
  assign cfg_rdata = st_r.rdata;
  assign rom_claim = st_r.claim;
  assign rom_decode_on = st_r.rom_dec;
  assign rom_window_base = st_r.rom_base;
  assign irq_line_number = st_r.irq_line;
  assign grant_cycles = st_r.gnt_cyc;
  assign latency_cycles = st_r.lat_cyc;

  // ========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // read strobe at a given offset
  sequence s_rd(logic [7:0] off);
    cfg_rd && (cfg_addr == off);
  endsequence

  // write at an offset followed straight by a read there
  sequence s_wr_rd(logic [7:0] off);
    (cfg_wr && (cfg_addr == off)) ##1 (cfg_rd && (cfg_addr == off));
  endsequence

  // access presented while the window is armed and the address lands in it;
  // judged on the registered settings, as the claim logic uses them
  sequence s_rom_armed;
    rom_acc_valid && rom_decode_on && mem_space_on
    && (rom_acc_addr[31:16] == rom_window_base);
  endsequence

  a_cap_ptr_fixed: assert property (
    s_rd(`PCFG_OFF_CAP_PTR) |=> cfg_rdata == 32'h0000_00DC)
    else $error("capability pointer not DCh");

  a_irq_pin_fixed: assert property (
    s_rd(`PCFG_OFF_IRQ_PIN) |=> cfg_rdata == 32'h0000_0001)
    else $error("interrupt pin not 01h");

  a_cap_id_next: assert property (
    s_rd(`PCFG_OFF_CAP_ID) |=> cfg_rdata == 32'h0000_0001)
    else $error("capability id not 01h");

  a_next_ptr_zero: assert property (
    s_rd(`PCFG_OFF_NEXT_PTR) |=> cfg_rdata == 32'h0000_0000)
    else $error("next capability pointer not zero");

  a_pm_version: assert property (
    s_rd(`PCFG_OFF_PM_CAP) |=> cfg_rdata[2:0] == 3'h1 && cfg_rdata[31:16] == 16'h0000)
    else $error("power capability version wrong");

  a_pm_d1_d2: assert property (
    s_rd(`PCFG_OFF_PM_CAP)
    |=> cfg_rdata[10:9] == $past(eeprom_bus_params_word[13:12]))
    else $error("d1 d2 support bits do not follow eeprom");

  a_pm_wake_mask: assert property (
    s_rd(`PCFG_OFF_PM_CAP)
    |=> cfg_rdata[15:11] == $past(eeprom_bus_params_word[15:11]))
    else $error("wake mask does not follow eeprom");

  a_min_gnt_read: assert property (
    s_rd(`PCFG_OFF_MIN_GNT)
    |=> cfg_rdata == {24'h00_0000, $past(min_burst_grant)})
    else $error("min grant readback wrong");

  a_max_lat_read: assert property (
    s_rd(`PCFG_OFF_MAX_LAT)
    |=> cfg_rdata == {24'h00_0000, $past(max_bus_latency)})
    else $error("max latency readback wrong");

  a_min_gnt_default: assert property (
    (s_rd(`PCFG_OFF_MIN_GNT) && !params_loaded && !ee_word_valid)
    |=> cfg_rdata[7:0] == 8'h06)
    else $error("min grant default not 6h");

  a_rom_ctrl_write: assert property (
    s_wr_rd(`PCFG_OFF_ROM_CTRL)
    |=> cfg_rdata[31:16] == $past(cfg_wdata[31:16], 2)
        && cfg_rdata[0] == $past(cfg_wdata[0], 2))
    else $error("rom control did not keep written base");

  a_rom_low_zero: assert property (
    s_rd(`PCFG_OFF_ROM_CTRL) |=> cfg_rdata[15:1] == 15'h0000)
    else $error("rom control bits 15:1 not zero");

  a_irq_line_hold: assert property (
    s_wr_rd(`PCFG_OFF_IRQ_LINE)
    |=> cfg_rdata == {24'h00_0000, $past(cfg_wdata[7:0], 2)})
    else $error("interrupt line did not hold written value");

  a_rom_ignore_off: assert property (
    (rom_acc_valid && !rom_decode_on) |=> !rom_claim)
    else $error("rom access claimed with decode off");

  a_rom_need_mem: assert property (
    (rom_acc_valid && !mem_space_on) |=> !rom_claim)
    else $error("rom access claimed with memory space off");

  a_rom_claim_hit: assert property (
    s_rom_armed |=> rom_claim)
    else $error("armed rom window not claimed");

  a_rdata_only_once: assert property (
    !cfg_rd |=> cfg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

endmodule // pcfg_tail

//--- tb/pcfg_host_model.sv
// host configuration software model driving the register port of the bank
module pcfg_host_model (
  input wire logic clk,               // bench clock
  input wire logic [31:0] cfg_rdata,  // read data from the bank
  output logic [7:0] cfg_addr,        // config byte offset
  output logic [31:0] cfg_wdata,      // config write data
  output logic cfg_wr,                // write strobe
  output logic cfg_rd                 // read strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ========================================================================
  // idle bus at time zero
  initial begin
    cfg_addr = 8'h00;
    cfg_wdata = 32'h00000000;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
  end

  // ========================================================================
  // one write cycle; gap idle edges first so the host can be slow
  task automatic cfg_write(input logic [7:0] a, input logic [31:0] d, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    // released bus shows the inverse, never a stale copy
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
  endtask

  // ========================================================================
  // one read cycle; data taken in the cycle after the strobe edge only
  task automatic cfg_read(input logic [7:0] a, input int gap, output logic [31:0] d);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'b0;
    cfg_addr <= ~a;
    #1 d = cfg_rdata;
  endtask

  // ========================================================================
  // write then read of the same offset with no idle cycle between them
  task automatic cfg_write_read(input logic [7:0] a, input logic [31:0] wd, input int gap,
                                output logic [31:0] d);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= wd;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b1;
    cfg_wdata <= ~wd;
    @(posedge clk);
    cfg_rd <= 1'b0;
    cfg_addr <= ~a;
    #1 d = cfg_rdata;
  endtask
endmodule // pcfg_host_model

//--- tb/tb_top.sv
// self-checking bench for the configuration tail register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_b;                       // clock and active-low reset
  logic [7:0] cfg_addr;                   // host bus
  logic [31:0] cfg_wdata, cfg_rdata;      // host data
  logic cfg_wr, cfg_rd;                   // host strobes
  logic mem_space_on, rom_acc_valid;      // rom window access side
  logic [31:0] rom_acc_addr;              // rom access address
  logic rom_claim, rom_decode_on;         // claim and enable outputs
  logic [15:0] rom_window_base;           // window base output
  logic [7:0] irq_line_number;            // irq line output
  logic ee_word_valid, ee_word_sel;       // eeprom strobe and select
  logic [15:0] ee_word;                   // eeprom word
  logic [12:0] grant_cycles, latency_cycles;  // derived counts
  int miscompares, n_tests;               // report counters
  int m_base, m_dec, m_irq, m_params, m_min, m_max;  // reference model state
  logic [31:0] lfsr, d, got;              // random source and scratch
  logic [7:0] offs[10] = '{8'h30, 8'h34, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'hDC, 8'hDD, 8'hDE, 8'h40};

  // ========================================================================
  // clock, 100 MHz
  always #5 clk = ~clk;

  pcfg_host_model pcfg_host_model_inst (.clk(clk), .cfg_rdata(cfg_rdata), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd));

  pcfg_tail pcfg_tail_inst (.clk(clk), .rst_b(rst_b), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .mem_space_on(mem_space_on), .rom_acc_valid(rom_acc_valid), .rom_acc_addr(rom_acc_addr),
    .rom_claim(rom_claim), .rom_decode_on(rom_decode_on), .rom_window_base(rom_window_base),
    .irq_line_number(irq_line_number), .ee_word_valid(ee_word_valid),
    .ee_word_sel(ee_word_sel), .ee_word(ee_word), .grant_cycles(grant_cycles),
    .latency_cycles(latency_cycles));

  // ========================================================================
  // reference model: reset state, chosen defaults of the eeprom latch
  task automatic model_reset();
    m_base = 0;
    m_dec = 0;
    m_irq = 0;
    m_params = 32'h00003800;
    m_min = 32'h00000006;
    m_max = 32'h00000020;
  endtask

  // expected read data per offset; unmapped reads give zero
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    logic [31:0] p;
    p = m_params;
    case (a)
      8'h30: return {m_base[15:0], 15'h0000, m_dec[0]};
      8'h34: return 32'h000000DC;
      8'h3C: return {24'h000000, m_irq[7:0]};
      8'h3D: return 32'h00000001;
      8'h3E: return {24'h000000, m_min[7:0]};
      8'h3F: return {24'h000000, m_max[7:0]};
      8'hDC: return 32'h00000001;
      8'hDD: return 32'h00000000;
      8'hDE: return {16'h0000, p[15:11], p[13], p[12], 6'h00, 3'h1};
      default: return 32'h00000000;
    endcase
  endfunction

  // ========================================================================
  // compare tasks, one per kind of result
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_flag(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // ========================================================================
  // helpers: random word, read and compare, sweep of every offset
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic rd_chk(input logic [7:0] a);
    lfsr = lfsr_next(lfsr);
    pcfg_host_model_inst.cfg_read(a, int'(lfsr[1:0] == 2'h3), got);
    chk_word(got, exp_rd(a));
  endtask

  task automatic check_all();
    for (int i = 0; i < 10; i++) begin
      rd_chk(offs[i]);
    end
    chk_word(32'(grant_cycles), 32'(m_min * 25));
    chk_word(32'(latency_cycles), 32'(m_max * 25));
  endtask

  // one rom access, claim looked at in the cycle after it
  task automatic rom_acc(input logic ms, input logic [31:0] a);
    @(posedge clk);
    mem_space_on <= ms;
    rom_acc_valid <= 1'b1;
    rom_acc_addr <= a;
    @(posedge clk);
    rom_acc_valid <= 1'b0;
    rom_acc_addr <= ~a;
    #1 chk_flag(rom_claim, ms & m_dec[0] & (a[31:16] == m_base[15:0]));
  endtask

  // one eeprom word; counts settle two edges after the strobe edge
  task automatic ee_load(input logic sel, input logic [15:0] w);
    @(posedge clk);
    ee_word_valid <= 1'b1;
    ee_word_sel <= sel;
    ee_word <= w;
    @(posedge clk);
    ee_word_valid <= 1'b0;
    ee_word <= ~w;
    if (sel) begin
      m_min = w[7:0];
      m_max = w[15:8];
    end else begin
      m_params = w;
    end
    @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ========================================================================
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  // ========================================================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    mem_space_on = 1'b0;
    rom_acc_valid = 1'b0;
    rom_acc_addr = 32'h00000000;
    ee_word_valid = 1'b0;
    ee_word_sel = 1'b0;
    ee_word = 16'h0000;
    lfsr = 32'h000121A6;
    miscompares = 0;
    n_tests = 0;
    model_reset();
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    check_all();
    // writes to read-only and unmapped offsets leave everything alone
    for (int i = 1; i < 10; i++) begin
      lfsr = lfsr_next(lfsr);
      if (offs[i] != 8'h3C) pcfg_host_model_inst.cfg_write(offs[i], lfsr, 0);
    end
    check_all();
    // rom control: junk in 15:1 dropped, base and enable held
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      d = {lfsr[31:1], k[0]};
      pcfg_host_model_inst.cfg_write_read(8'h30, d, k % 2, got);
      m_base = d[31:16];
      m_dec = d[0];
      chk_word(got, exp_rd(8'h30));
      chk_word(32'(rom_window_base), exp_rd(8'h30) >> 16);
      chk_flag(rom_decode_on, m_dec[0]);
      // every enable and hit combination on the window
      for (int j = 0; j < 4; j++) begin
        rom_acc(j[0], j[1] ? {d[31:16], lfsr[15:0]} : {~d[31:16], lfsr[15:0]});
      end
    end
    // interrupt line keeps what software wrote
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      // software only writes an irq number 1-15, or 0 / FFh for disabled
      m_irq = (k == 3) ? 8'hFF : {4'h0, lfsr[3:0]};
      pcfg_host_model_inst.cfg_write_read(8'h3C, {lfsr[31:8], m_irq[7:0]}, 0, got);
      chk_word(got, exp_rd(8'h3C));
      chk_word(32'(irq_line_number), 32'(m_irq[7:0]));
    end
    // eeprom words of both kinds reach capability, grant and latency
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      ee_load(k[0], lfsr[15:0]);
      check_all();
    end
    // reset in mid-run brings back the reset view
    @(posedge clk);
    rst_b <= 1'b0;
    model_reset();
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    check_all();
    tally_and_finish();
  end
endmodule // tb_top
